// ===== design/dit_dual_input_timer.sv
// Two independent down-counters paced by the timer tick clock.
// Assumes control inputs come from logic on core_clk; the tick clock is a pin.
`timescale 1ns/10ps

// What this block does
// - Two independent down-counters, each selectable as 32-bit or 16-bit wide.
// - Counters decrement only on rising edges of the slow timer tick clock.
// - Each counter runs free-running, periodic or one-shot.
// - Free-running: after zero the counter wraps to its width's maximum.
// - Periodic: interrupt each period, reload programmed value after zero.
// - One-shot: interrupt once at zero, then stay halted until reloaded or disabled.
// - Per-counter prescale setting scales the decrement rate against the tick.
module dit_dual_input_timer #(
  parameter int unsigned NUM_CNT = 2
) (
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     timer_tick_clock,
  input  wire logic [NUM_CNT-1:0]       cfg_enable,
  input  wire logic [NUM_CNT-1:0][1:0]  cfg_mode,
  input  wire logic [NUM_CNT-1:0]       cfg_wide,
  input  wire logic [NUM_CNT-1:0][1:0]  cfg_prescale,
  input  wire logic [NUM_CNT-1:0]       load_strobe,
  input  wire logic [NUM_CNT-1:0][31:0] load_value,
  input  wire logic [NUM_CNT-1:0]       irq_clear,
  output wire logic [NUM_CNT-1:0][31:0] cnt_value,
  output wire logic [NUM_CNT-1:0]       irq_pending,
  output wire logic [NUM_CNT-1:0]       cnt_running
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Mask of the active counter width.
  function automatic logic [31:0] width_mask(input logic wide);
    width_mask = wide ? dit_pkg::MASK_32 : dit_pkg::MASK_16;
  endfunction

  // Terminal count of the prescaler; the reserved code acts as divide by 256.
  function automatic logic [7:0] pre_limit(input logic [1:0] code);
    logic [7:0] lim;
    lim = dit_pkg::PRE_LIM_DIV256;
    unique case (code)
      dit_pkg::PRE_DIV1:   lim = dit_pkg::PRE_LIM_DIV1;
      dit_pkg::PRE_DIV16:  lim = dit_pkg::PRE_LIM_DIV16;
      dit_pkg::PRE_DIV256: lim = dit_pkg::PRE_LIM_DIV256;
      default:             lim = dit_pkg::PRE_LIM_DIV256;
    endcase
    pre_limit = lim;
  endfunction

  // ----------------------------------------------------------------------
  // Tick from the timer tick clock
  // ----------------------------------------------------------------------
  dit_tick_if tick_bus ();

  dit_tick_sync u_tick_sync (
    .core_clk         (core_clk),
    .srst             (srst),
    .timer_tick_clock (timer_tick_clock),
    .tick_o           (tick_bus)
  );

  // Single-cycle pulse, one for each rising edge of the tick clock pin once the synchroniser has filled after reset.
  logic tick;
  assign tick = tick_bus.tick;

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  // independent counter pair
  for (genvar k = 0; k < NUM_CNT; k++) begin : g_cnt

    dit_pkg::dit_state_t state_ff;
    dit_pkg::dit_state_t nxt_state;
    logic [31:0]         value_ff;
    logic [31:0]         nxt_value;
    logic [31:0]         reload_ff;
    logic [31:0]         nxt_reload;
    logic [7:0]          pre_ff;
    logic [7:0]          nxt_pre;
    logic                pend_ff;
    logic                nxt_pend;
    logic                run_ff;
    logic                nxt_run;
    logic                fire;
    logic [31:0]         mask;
    logic [31:0]         cur;
    logic [7:0]          limit;

    // --------------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------------
    always_comb begin
      nxt_state  = state_ff;
      nxt_value  = value_ff;
      nxt_reload = reload_ff;
      nxt_pre    = pre_ff;
      fire       = 1'b0;
      mask       = width_mask(cfg_wide[k]);
      cur        = value_ff & mask;
      limit      = pre_limit(cfg_prescale[k]);

      unique case (state_ff)
        dit_pkg::ST_IDLE: begin
          // The prescaler stays clear while stopped, so a start counts whole periods.
          nxt_pre = dit_pkg::RST_PRE;
          if (cfg_enable[k]) begin
            nxt_state = dit_pkg::ST_RUN;
          end
        end
        dit_pkg::ST_RUN: begin
          if (!cfg_enable[k]) begin
            nxt_state = dit_pkg::ST_IDLE;
          end else if (tick) begin
            if (pre_ff >= limit) begin
              nxt_pre = dit_pkg::RST_PRE;
              unique case (cfg_mode[k])
                dit_pkg::MODE_PERIODIC: begin
                  // reload after zero
                  // A reload value of zero fires on every step.
                  if (cur == 32'h0000_0000) begin
                    nxt_value = reload_ff & mask;
                  end else begin
                    nxt_value = (cur - 32'h0000_0001) & mask;
                  end
                  fire = (nxt_value == 32'h0000_0000);
                end
                dit_pkg::MODE_ONESHOT: begin
                  // fire once and halt
                  // A count loaded as zero fires on its first step, as a count of one does.
                  if (cur <= 32'h0000_0001) begin
                    nxt_value = 32'h0000_0000;
                    fire      = 1'b1;
                    nxt_state = dit_pkg::ST_HALT;
                  end else begin
                    nxt_value = cur - 32'h0000_0001;
                  end
                end
                default: begin
                  // wrap to maximum
                  // The reserved mode code counts as free-running too.
                  if (cur == 32'h0000_0000) begin
                    nxt_value = mask;
                  end else begin
                    nxt_value = cur - 32'h0000_0001;
                  end
                  fire = (nxt_value == 32'h0000_0000);
                end
              endcase
            end else begin
              nxt_pre = pre_ff + 8'h01;
            end
          end
        end
        dit_pkg::ST_HALT: begin
          nxt_pre = dit_pkg::RST_PRE;
          if (!cfg_enable[k]) begin
            nxt_state = dit_pkg::ST_IDLE;
          end
        end
        default: begin
          nxt_state = dit_pkg::ST_IDLE;
        end
      endcase

      // A new count overrides a decrement in the same cycle and restarts
      // the prescaler, so the first period after a load is always whole.
      if (load_strobe[k]) begin
        nxt_value  = load_value[k] & mask;
        nxt_reload = load_value[k];
        nxt_pre    = dit_pkg::RST_PRE;
        if (state_ff == dit_pkg::ST_HALT) begin
          nxt_state = cfg_enable[k] ? dit_pkg::ST_RUN : dit_pkg::ST_IDLE;
        end
      end

      nxt_pend = (pend_ff & ~irq_clear[k]) | fire;
      // The running flag follows the next state, so it always matches state_ff.
      nxt_run  = (nxt_state == dit_pkg::ST_RUN);
    end

    // --------------------------------------------------------------------
    // State registers
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
      if (srst) begin
        state_ff  <= dit_pkg::ST_IDLE;
        value_ff  <= dit_pkg::RST_VALUE;
        reload_ff <= dit_pkg::RST_RELOAD;
        pre_ff    <= dit_pkg::RST_PRE;
        pend_ff   <= 1'b0;
        run_ff    <= 1'b0;
      end else begin
        state_ff  <= nxt_state;
        value_ff  <= nxt_value;
        reload_ff <= nxt_reload;
        pre_ff    <= nxt_pre;
        pend_ff   <= nxt_pend;
        run_ff    <= nxt_run;
      end
    end

    // --------------------------------------------------------------------
    // Outputs, taken straight from the registers
    // --------------------------------------------------------------------
    assign cnt_value[k]   = value_ff;
    assign irq_pending[k] = pend_ff;
    assign cnt_running[k] = run_ff;

  end

endmodule // dit_dual_input_timer

// ===== design/dit_tick_sync.sv
// Synchroniser and rising edge detector for the timer tick clock.
// Assumes the tick clock is well below half the core clock rate.
`timescale 1ns/10ps
module dit_tick_sync (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic timer_tick_clock,
  dit_tick_if.src   tick_o
);

  // ----------------------------------------------------------------------
  // Two stage synchroniser, edge stage and pulse register
  // ----------------------------------------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic tick_ff;
  logic nxt_tick;
  logic [1:0] fill_ff;
  logic [1:0] nxt_fill;

  // Edges are ignored until the synchroniser holds the pin's real level,
  // so a pin that is high when reset ends is not taken as a rising edge.
  always_comb begin
    nxt_fill = (fill_ff == dit_pkg::SYNC_FILL) ? fill_ff : fill_ff + 2'h1;
    nxt_tick = sync_ff & ~last_ff & (fill_ff == dit_pkg::SYNC_FILL);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      tick_ff <= 1'b0;
      fill_ff <= 2'h0;
    end else begin
      meta_ff <= timer_tick_clock;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      tick_ff <= nxt_tick;
      fill_ff <= nxt_fill;
    end
  end

  assign tick_o.tick = tick_ff;

endmodule // dit_tick_sync

// ===== include/dit_pkg.sv
// Shared constants and types of the dual input timer.
// Assumes a single core clock that runs far faster than the timer tick clock.
package dit_pkg;

  // ----------------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ  = 10_000_000;
  localparam int unsigned TICK_CLK_HZ  = 32_000;
  // Core cycles after reset before the tick synchroniser holds a real pin level.
  localparam logic [1:0]  SYNC_FILL    = 2'h3;

  // ----------------------------------------------------------------------
  // Counter modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_FREE     = 2'h0;
  localparam logic [1:0] MODE_PERIODIC = 2'h1;
  localparam logic [1:0] MODE_ONESHOT  = 2'h2;

  // ----------------------------------------------------------------------
  // Prescale codes and the terminal count of the prescaler for each
  // ----------------------------------------------------------------------
  localparam logic [1:0] PRE_DIV1      = 2'h0;
  localparam logic [1:0] PRE_DIV16     = 2'h1;
  localparam logic [1:0] PRE_DIV256    = 2'h2;
  localparam logic [7:0] PRE_LIM_DIV1  = 8'h00;
  localparam logic [7:0] PRE_LIM_DIV16 = 8'h0F;
  localparam logic [7:0] PRE_LIM_DIV256 = 8'hFF;

  // ----------------------------------------------------------------------
  // Width masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] MASK_16      = 32'h0000_FFFF;
  localparam logic [31:0] MASK_32      = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_VALUE    = 32'h0000_0000;
  localparam logic [31:0] RST_RELOAD   = 32'h0000_0000;
  localparam logic [7:0]  RST_PRE      = 8'h00;

  // ----------------------------------------------------------------------
  // Counter states, Gray coded along idle, run, halt
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b11
  } dit_state_t;

endpackage

// ===== include/dit_tick_if.sv
// Carrier of the synchronised tick pulse between the timer's modules.
// Assumes source and sink share core_clk.
`timescale 1ns/10ps
interface dit_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// ===== verification/dit_dual_input_timer_tb.sv
// Self-checking bench driving the dual input timer ports directly.
// Assumes dit_pkg; the bench makes a fast tick clock to keep runs short.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dit_dual_input_timer_tb;
  logic                  core_clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  timer_tick_clock = 1'b0;
  logic [1:0]            cfg_enable = '0;
  logic [1:0][1:0]       cfg_mode = '0;
  logic [1:0]            cfg_wide = '0;
  logic [1:0][1:0]       cfg_prescale = '0;
  logic [1:0]            load_strobe = '0;
  logic [1:0][31:0]      load_value = '0;
  logic [1:0]            irq_clear = '0;
  wire logic [1:0][31:0] cnt_value;
  wire logic [1:0]       irq_pending;
  wire logic [1:0]       cnt_running;
  logic [1:0]            pcode [3] = '{dit_pkg::PRE_DIV1, dit_pkg::PRE_DIV16, dit_pkg::PRE_DIV256};
  int                    pdiv [3] = '{1, 16, 256};
  int                    mismatches = 0;
  int                    cmp_count = 0;
  int                    cyc_cnt = 0;

  dit_dual_input_timer #(.NUM_CNT(2)) DUT (.core_clk, .srst, .timer_tick_clock, .cfg_enable,
    .cfg_mode, .cfg_wide, .cfg_prescale, .load_strobe, .load_value, .irq_clear, .cnt_value,
    .irq_pending, .cnt_running);

  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      timer_tick_clock = 1'b1;
      cyc(4);
      timer_tick_clock = 1'b0;
      cyc(4);
    end
  endtask
  task automatic setup(input int i, input logic [1:0] m, input logic w,
                       input logic [1:0] p, input logic [31:0] v);
    cfg_enable[i] = 1'b0;
    cfg_mode[i] = m;
    cfg_wide[i] = w;
    cfg_prescale[i] = p;
    load_strobe[i] = 1'b1;
    load_value[i] = v;
    cyc(1);
    load_strobe[i] = 1'b0;
    cfg_enable[i] = 1'b1;
    cyc(2);
  endtask
  task automatic clr(input int i);
    irq_clear[i] = 1'b1;
    cyc(1);
    irq_clear[i] = 1'b0;
    cyc(1);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    cyc(6);
    srst = 1'b0;
    cyc(1);
    `CHK({cnt_value, irq_pending, cnt_running}, 68'h0)
    setup(0, dit_pkg::MODE_FREE, 1'b0, dit_pkg::PRE_DIV1, 32'h0000_0002);
    setup(1, dit_pkg::MODE_FREE, 1'b1, dit_pkg::PRE_DIV1, 32'h0000_0001);
    cyc(10);
    `CHK(cnt_value, {32'h0000_0001, 32'h0000_0002})
    tick(1);
    `CHK(irq_pending, 2'b10)
    tick(1);
    `CHK(cnt_value, {32'hFFFF_FFFF, 32'h0000_0000})
    tick(1);
    `CHK(cnt_value, {32'hFFFF_FFFE, 32'h0000_FFFF})
    cfg_enable[1] = 1'b0;
    clr(1);
    clr(0);
    `CHK(irq_pending, 2'b00)
    setup(0, dit_pkg::MODE_PERIODIC, 1'b0, dit_pkg::PRE_DIV1, 32'h0000_0003);
    tick(3);
    `CHK({cnt_value[0], irq_pending[0]}, {32'h0000_0000, 1'b1})
    tick(1);
    `CHK(cnt_value[0], 32'h0000_0003)
    clr(0);
    setup(0, dit_pkg::MODE_ONESHOT, 1'b0, dit_pkg::PRE_DIV1, 32'h0003_0001);
    `CHK(cnt_value[0], 32'h0000_0001)
    tick(1);
    `CHK({cnt_value[0], irq_pending[0], cnt_running[0]}, {32'h0000_0000, 2'b10})
    clr(0);
    tick(2);
    `CHK({cnt_value[0], irq_pending[0], cnt_running[0]}, 34'h0)
    // A new count while halted and still enabled restarts the counter at once.
    load_value[0] = 32'h0000_0002;
    load_strobe[0] = 1'b1;
    cyc(1);
    load_strobe[0] = 1'b0;
    `CHK({cnt_value[0], cnt_running[0]}, {32'h0000_0002, 1'b1})
    tick(1);
    // A clear in the very cycle of the zero step loses against the new event.
    timer_tick_clock = 1'b1;
    cyc(3);
    irq_clear[0] = 1'b1;
    cyc(1);
    irq_clear[0] = 1'b0;
    timer_tick_clock = 1'b0;
    cyc(4);
    `CHK({cnt_value[0], irq_pending[0], cnt_running[0]}, {32'h0000_0000, 2'b10})
    for (int k = 0; k < 3; k++) begin
      setup(0, dit_pkg::MODE_FREE, 1'b0, pcode[k], 32'h0000_0005);
      tick(pdiv[k] - 1);
      `CHK(cnt_value[0], 32'h0000_0005)
      tick(1);
      `CHK(cnt_value[0], 32'h0000_0004)
    end
    // A reset with the tick pin held high must not count a false edge afterwards.
    srst = 1'b1;
    timer_tick_clock = 1'b1;
    cfg_prescale[0] = dit_pkg::PRE_DIV1;
    cyc(4);
    srst = 1'b0;
    cyc(6);
    `CHK({cnt_value, irq_pending, cnt_running}, 68'h1)
    final_report();
  end
endmodule // dit_dual_input_timer_tb

// ===== verification/dit_timer_checker.sv
// Assertions on counter 0 of the dual input timer.
// Assumes the top module ports and the dit_pkg constants.
`timescale 1ns/10ps
module dit_timer_checker #(
  parameter int unsigned NUM_CNT = 2
) (
  input wire logic                     core_clk,
  input wire logic                     srst,
  input wire logic                     timer_tick_clock,
  input wire logic [NUM_CNT-1:0]       cfg_enable,
  input wire logic [NUM_CNT-1:0][1:0]  cfg_mode,
  input wire logic [NUM_CNT-1:0]       cfg_wide,
  input wire logic [NUM_CNT-1:0][1:0]  cfg_prescale,
  input wire logic [NUM_CNT-1:0]       load_strobe,
  input wire logic [NUM_CNT-1:0][31:0] load_value,
  input wire logic [NUM_CNT-1:0]       irq_clear,
  input wire logic [NUM_CNT-1:0][31:0] cnt_value,
  input wire logic [NUM_CNT-1:0]       irq_pending,
  input wire logic [NUM_CNT-1:0]       cnt_running
);
  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic [31:0] msk;
  logic [31:0] ld_msk;
  logic [31:0] rld_ff, nxt_rld;
  logic [3:0]  quiet_ff, nxt_quiet;
  logic        pin_ff;
  assign msk    = cfg_wide[0] ? dit_pkg::MASK_32 : dit_pkg::MASK_16;
  assign ld_msk = load_value[0] & msk;
  // Quiet counts core cycles since the tick pin last moved, saturating.
  always_comb begin
    nxt_rld   = load_strobe[0] ? load_value[0] : rld_ff;
    nxt_quiet = (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
    if (timer_tick_clock != pin_ff) begin
      nxt_quiet = 4'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    rld_ff   <= srst ? 32'h0000_0000 : nxt_rld;
    quiet_ff <= srst ? 4'h0 : nxt_quiet;
    pin_ff   <= timer_tick_clock;
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_from_zero(logic [1:0] m);
    cfg_mode[0] == m && $changed(cnt_value[0]) && !$past(load_strobe[0])
      && $past(cnt_value[0]) == 32'h0000_0000;
  endsequence
  a_load_shows: assert property (load_strobe[0] |=> cnt_value[0] == $past(ld_msk))
    else $error("load value not shown");
  a_quiet_hold: assert property (quiet_ff >= 4'h7 && !$past(load_strobe[0])
    |-> $stable(cnt_value[0])) else $error("count moved without tick");
  a_free_wrap: assert property (s_from_zero(dit_pkg::MODE_FREE) |-> cnt_value[0] == msk)
    else $error("free wrap not to maximum");
  a_period_reload: assert property (s_from_zero(dit_pkg::MODE_PERIODIC)
    |-> cnt_value[0] == (rld_ff & msk)) else $error("periodic reload wrong");
  a_oneshot_halt: assert property (cfg_mode[0] == dit_pkg::MODE_ONESHOT
    && $fell(cnt_running[0]) && cfg_enable[0] && $past(cfg_enable[0])
    |-> cnt_value[0] == 32'h0000_0000) else $error("one-shot halted off zero");
  a_irq_zero: assert property ($rose(irq_pending[0]) && !$past(load_strobe[0])
    |-> cnt_value[0] == 32'h0000_0000) else $error("pending set off zero");
  a_irq_clear: assert property (irq_clear[0] && !cnt_running[0] |=> !irq_pending[0])
    else $error("pending not cleared");
  a_irq_sticky: assert property (irq_pending[0] && !irq_clear[0] |=> irq_pending[0])
    else $error("pending dropped");
endmodule // dit_timer_checker

bind dit_dual_input_timer dit_timer_checker #(.NUM_CNT(NUM_CNT)) u_chk (
  .core_clk         (core_clk),
  .srst             (srst),
  .timer_tick_clock (timer_tick_clock),
  .cfg_enable       (cfg_enable),
  .cfg_mode         (cfg_mode),
  .cfg_wide         (cfg_wide),
  .cfg_prescale     (cfg_prescale),
  .load_strobe      (load_strobe),
  .load_value       (load_value),
  .irq_clear        (irq_clear),
  .cnt_value        (cnt_value),
  .irq_pending      (irq_pending),
  .cnt_running      (cnt_running)
);
